// ==== verilog/mres_pkg.sv ====
// Purpose: constants for the mac receive error statistics block
// Assumes: apb with 32-bit data, 125 MHz clock
// Notes: counters sit in the low bits of one aligned word each
// Functional notes
// - 8-bit counter of received frames that saw rx_er asserted.
// - symbol error frame of 64 bytes up to max length also counts as fcs error.
// - symbol error frame above max length counts as jabber instead.
// - max length 1518, 1536 with big frame bit 8, 10240 with jumbo bit 3.
// - 8-bit excess length counter: frame above max length, no crc/align/symbol error.
// - 8-bit jabber counter: frame above max length with crc, align or symbol error.
// - 8-bit undersize counter: frame below 64 bytes with no error.
// - half duplex: count frame when col not seen within 96 bit times of tx_en fall.
// - 8-bit counter of frames with measured length below the length field.
// - mismatch checking only while config bit 16 is set.
// - no mismatch count for length/type 0x0600 or above, or excess length frames.
// - 16-bit counter of transmitted pause frames.
package mres_pkg;
  localparam logic [7:0]  ADDR_SYMBOL   = 8'h00;
  localparam logic [7:0]  ADDR_EXCESS   = 8'h04;
  localparam logic [7:0]  ADDR_JABBER   = 8'h08;
  localparam logic [7:0]  ADDR_UNDER    = 8'h0c;
  localparam logic [7:0]  ADDR_SQE      = 8'h10;
  localparam logic [7:0]  ADDR_MISMATCH = 8'h14;
  localparam logic [7:0]  ADDR_PAUSE    = 8'h18;
  localparam logic [7:0]  ADDR_FCS      = 8'h1c;
  localparam logic [7:0]  ADDR_CONFIG   = 8'h20;
  localparam int          BIT_JUMBO     = 3;
  localparam int          BIT_BIG       = 8;
  localparam int          BIT_LENCHK    = 16;
  localparam int          BIT_HALF      = 0;
  localparam int          BIT_SLOW      = 1;
  // slow flag must survive the mask or the 10 Mb/s window is unreachable
  localparam logic [31:0] CONFIG_MASK   = 32'h0001_010b;
  localparam logic [13:0] LEN_MIN       = 14'h0040;
  localparam logic [13:0] LEN_STD       = 14'h05ee;
  localparam logic [13:0] LEN_BIG       = 14'h0600;
  localparam logic [13:0] LEN_JUMBO     = 14'h2800;
  localparam logic [15:0] TYPE_MIN      = 16'h0600;
  localparam int          CLK_MHZ       = 125;
  localparam int          BIT_NS_100M   = 10;
  localparam int          SQE_BITS      = 96;
  // 100 Mb/s bit time; 10 Mb/s users set the slow flag (10x)
  localparam int          SQE_CYC_FAST  = SQE_BITS * BIT_NS_100M * CLK_MHZ / 1000;
  localparam int          SQE_CYC_SLOW  = SQE_CYC_FAST * 10;
  localparam logic [7:0]  CNT8_RST      = 8'h00;
  localparam logic [15:0] CNT16_RST     = 16'h0000;
  localparam logic [31:0] READ_ZERO     = 32'h0000_0000;
  typedef enum logic [1:0] {SQE_IDLE, SQE_TX, SQE_WAIT} mres_sqe_type;
endpackage

// ==== verilog/mres_evt_if.sv ====
`timescale 1ns/1ps
// Purpose: event strobes between sqe checker and counters
// Assumes: one clock domain
// Notes: sqe_fail is one cycle wide; sqe_busy is a level held while the checker is not idle
interface mres_evt_if;
  logic sqe_fail;
  logic sqe_busy;
  modport src (output sqe_fail, output sqe_busy);
  modport dst (input sqe_fail, input sqe_busy);
endinterface

// ==== verilog/mres_sqe_check.sv ====
`timescale 1ns/1ps
// Purpose: watch col after tx_en falls in half duplex
// Assumes: mii signals synchronous to clk
// Notes: window length in clock cycles depends on line speed
module mres_sqe_check (
  input  wire logic   clk,
  input  wire logic   sys_rst,
  input  wire logic   half_duplex,
  input  wire logic   slow_link,
  input  wire logic   tx_en,
  input  wire logic   col,
  mres_evt_if.src     evt
);
  mres_pkg::mres_sqe_type state_reg;
  logic [15:0]            win_reg;
  logic [15:0]            win_len;

  assign win_len = slow_link ? 16'(mres_pkg::SQE_CYC_SLOW) : 16'(mres_pkg::SQE_CYC_FAST);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg    <= mres_pkg::SQE_IDLE;
      win_reg      <= 16'h0000;
      evt.sqe_fail <= 1'b0;
    end else begin
      evt.sqe_fail <= 1'b0;
      case (state_reg)
        mres_pkg::SQE_IDLE: begin
          if (tx_en && half_duplex) begin
            state_reg <= mres_pkg::SQE_TX;
          end
        end
        mres_pkg::SQE_TX: begin
          if (!tx_en) begin
            state_reg <= mres_pkg::SQE_WAIT;
            win_reg   <= win_len;
          end
        end
        mres_pkg::SQE_WAIT: begin
          if (col) begin
            state_reg <= mres_pkg::SQE_IDLE;
          end else if (win_reg <= 16'h0001) begin
            evt.sqe_fail <= 1'b1;
            state_reg    <= mres_pkg::SQE_IDLE;
          end else begin
            win_reg <= win_reg - 16'h0001;
          end
        end
        default: state_reg <= mres_pkg::SQE_IDLE;
      endcase
    end
  end

  assign evt.sqe_busy = (state_reg != mres_pkg::SQE_IDLE);
endmodule

// ==== verilog/mres_top.sv ====
`timescale 1ns/1ps
// Purpose: receive error statistics counters with apb access
// Assumes: frame end strobe carries length and error flags for that frame
// Notes: counters wrap; a bus write in the same cycle as an event wins
module mres_top (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_dv,
  input  wire logic        rx_er,
  input  wire logic        rx_frame_end,
  input  wire logic [13:0] rx_frame_len,
  input  wire logic [15:0] rx_len_field,
  input  wire logic        rx_crc_err,
  input  wire logic        rx_align_err,
  input  wire logic        tx_en,
  input  wire logic        col,
  input  wire logic        tx_pause_sent,
  output logic             sqe_active
);
  mres_evt_if evt ();

  logic [31:0] config_reg;
  logic [7:0]  symbol_error_counter;
  logic [7:0]  excess_length_counter;
  logic [7:0]  jabber_counter;
  logic [7:0]  undersize_counter;
  logic [7:0]  sqe_error_counter;
  logic [7:0]  length_mismatch_counter;
  logic [15:0] pause_tx_counter;
  logic [7:0]  fcs_counter;
  logic        sym_seen_reg;
  logic [13:0] max_len;
  logic        sym_err;
  logic        any_err;
  logic        too_long;
  logic        too_short;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [31:0] rd_next;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  mres_sqe_check u_sqe (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .half_duplex (config_reg[mres_pkg::BIT_HALF]),
    .slow_link   (config_reg[mres_pkg::BIT_SLOW]),
    .tx_en       (tx_en),
    .col         (col),
    .evt         (evt)
  );

  // jumbo takes priority over big when both are set
  always_comb begin
    if (config_reg[mres_pkg::BIT_JUMBO]) begin
      max_len = mres_pkg::LEN_JUMBO;
    end else if (config_reg[mres_pkg::BIT_BIG]) begin
      max_len = mres_pkg::LEN_BIG;
    end else begin
      max_len = mres_pkg::LEN_STD;
    end
  end

  // rx_er at the closing cycle still belongs to this frame
  assign sym_err   = sym_seen_reg | rx_er;
  assign any_err   = sym_err | rx_crc_err | rx_align_err;
  assign too_long  = rx_frame_len > max_len;
  assign too_short = rx_frame_len < mres_pkg::LEN_MIN;

  always_ff @(posedge clk) begin
    if (sys_rst || rx_frame_end) begin
      sym_seen_reg <= 1'b0;
    end else if (rx_dv && rx_er) begin
      sym_seen_reg <= 1'b1;
    end
  end

  // zero wait state slave: access phase always completes at once
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign addr_ok = hit(paddr, mres_pkg::ADDR_SYMBOL) | hit(paddr, mres_pkg::ADDR_EXCESS)
                 | hit(paddr, mres_pkg::ADDR_JABBER) | hit(paddr, mres_pkg::ADDR_UNDER)
                 | hit(paddr, mres_pkg::ADDR_SQE) | hit(paddr, mres_pkg::ADDR_MISMATCH)
                 | hit(paddr, mres_pkg::ADDR_PAUSE) | hit(paddr, mres_pkg::ADDR_FCS)
                 | hit(paddr, mres_pkg::ADDR_CONFIG);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      config_reg <= mres_pkg::READ_ZERO;
    end else if (wr_en && hit(paddr, mres_pkg::ADDR_CONFIG)) begin
      config_reg <= pwdata & mres_pkg::CONFIG_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      symbol_error_counter <= mres_pkg::CNT8_RST;
    end else if (wr_en && hit(paddr, mres_pkg::ADDR_SYMBOL)) begin
      symbol_error_counter <= pwdata[7:0];
    end else if (rx_frame_end && sym_err) begin
      symbol_error_counter <= symbol_error_counter + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fcs_counter <= mres_pkg::CNT8_RST;
    end else if (wr_en && hit(paddr, mres_pkg::ADDR_FCS)) begin
      fcs_counter <= pwdata[7:0];
    end else if (rx_frame_end && !too_long && !too_short
                 && (sym_err || rx_crc_err || rx_align_err)) begin
      fcs_counter <= fcs_counter + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      excess_length_counter <= mres_pkg::CNT8_RST;
    end else if (wr_en && hit(paddr, mres_pkg::ADDR_EXCESS)) begin
      excess_length_counter <= pwdata[7:0];
    end else if (rx_frame_end && too_long && !any_err) begin
      excess_length_counter <= excess_length_counter + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      jabber_counter <= mres_pkg::CNT8_RST;
    end else if (wr_en && hit(paddr, mres_pkg::ADDR_JABBER)) begin
      jabber_counter <= pwdata[7:0];
    end else if (rx_frame_end && too_long && any_err) begin
      jabber_counter <= jabber_counter + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      undersize_counter <= mres_pkg::CNT8_RST;
    end else if (wr_en && hit(paddr, mres_pkg::ADDR_UNDER)) begin
      undersize_counter <= pwdata[7:0];
    end else if (rx_frame_end && too_short && !any_err) begin
      undersize_counter <= undersize_counter + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sqe_error_counter <= mres_pkg::CNT8_RST;
    end else if (wr_en && hit(paddr, mres_pkg::ADDR_SQE)) begin
      sqe_error_counter <= pwdata[7:0];
    end else if (evt.sqe_fail) begin
      sqe_error_counter <= sqe_error_counter + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      length_mismatch_counter <= mres_pkg::CNT8_RST;
    end else if (wr_en && hit(paddr, mres_pkg::ADDR_MISMATCH)) begin
      length_mismatch_counter <= pwdata[7:0];
    end else if (rx_frame_end && config_reg[mres_pkg::BIT_LENCHK]
                 && rx_len_field < mres_pkg::TYPE_MIN && !too_long
                 && {2'b00, rx_frame_len} < rx_len_field) begin
      length_mismatch_counter <= length_mismatch_counter + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pause_tx_counter <= mres_pkg::CNT16_RST;
    end else if (wr_en && hit(paddr, mres_pkg::ADDR_PAUSE)) begin
      pause_tx_counter <= pwdata[15:0];
    end else if (tx_pause_sent) begin
      pause_tx_counter <= pause_tx_counter + 16'h0001;
    end
  end

  always_comb begin
    rd_next = mres_pkg::READ_ZERO;
    case (paddr)
      mres_pkg::ADDR_SYMBOL:   rd_next = {24'h000000, symbol_error_counter};
      mres_pkg::ADDR_EXCESS:   rd_next = {24'h000000, excess_length_counter};
      mres_pkg::ADDR_JABBER:   rd_next = {24'h000000, jabber_counter};
      mres_pkg::ADDR_UNDER:    rd_next = {24'h000000, undersize_counter};
      mres_pkg::ADDR_SQE:      rd_next = {24'h000000, sqe_error_counter};
      mres_pkg::ADDR_MISMATCH: rd_next = {24'h000000, length_mismatch_counter};
      mres_pkg::ADDR_PAUSE:    rd_next = {16'h0000, pause_tx_counter};
      mres_pkg::ADDR_FCS:      rd_next = {24'h000000, fcs_counter};
      mres_pkg::ADDR_CONFIG:   rd_next = config_reg;
      default:                 rd_next = mres_pkg::READ_ZERO;
    endcase
  end

  // answer registered in setup cycle so pready is a flop and access takes one cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata  <= mres_pkg::READ_ZERO;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      if (psel && !penable && !pwrite) begin
        prdata <= rd_next;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sqe_active <= 1'b0;
    end else begin
      sqe_active <= evt.sqe_busy;
    end
  end
endmodule

// ==== verification/mres_props.sv ====
`timescale 1ns/1ps
// Purpose: bus and counter properties at the top ports
// Assumes: zero wait apb, config tracked from bus writes
// Notes: readback is checked only while no event could move a counter
module mres_props (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_frame_end,
  input wire logic        tx_en,
  input wire logic        tx_pause_sent,
  input wire logic        sqe_active
);
  logic [7:0] wa_reg;
  logic [7:0] wd_reg;
  logic       clean_reg;
  logic       half_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence rd_setup_s;
    psel && !penable && !pwrite;
  endsequence
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clean_reg <= 1'b0;
      half_reg  <= 1'b0;
    end else if (psel && penable && pready && pwrite) begin
      wa_reg    <= paddr;
      wd_reg    <= pwdata[7:0];
      clean_reg <= 1'b1;
      if (paddr == mres_pkg::ADDR_CONFIG) half_reg <= pwdata[mres_pkg::BIT_HALF];
    end else if (rx_frame_end || tx_pause_sent || tx_en || sqe_active) begin
      clean_reg <= 1'b0;
    end
  end
  chk_ready_after_setup: assert property (setup_s |=> pready)
    else $error("no pready after setup");
  chk_ready_one_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_unmapped_error: assert property (setup_s ##0 paddr > 8'h20 |=> pslverr)
    else $error("no pslverr on unmapped address");
  chk_mapped_no_error: assert property (setup_s ##0 paddr <= 8'h20 |=> !pslverr)
    else $error("pslverr on mapped address");
  chk_unmapped_zero: assert property (rd_setup_s ##0 paddr > 8'h20 |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_upper_zero: assert property (rd_setup_s ##0 paddr <= 8'h14 |=> prdata[31:8] == 24'h0)
    else $error("counter upper bits not zero");
  chk_pause_upper: assert property (rd_setup_s ##0 paddr == 8'h18 |=> prdata[31:16] == 16'h0)
    else $error("pause upper bits not zero");
  chk_write_readback: assert property (rd_setup_s ##0 (clean_reg && paddr == wa_reg
    && paddr <= 8'h14) |=> prdata == {24'h0, wd_reg})
    else $error("written counter not read back");
  chk_rdata_holds: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("prdata changed without read");
  chk_sqe_tracks: assert property (half_reg && tx_en |-> ##[1:2] sqe_active)
    else $error("sqe tracking not active");
endmodule
bind mres_top mres_props u_props (.clk(clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rx_frame_end(rx_frame_end), .tx_en(tx_en),
  .tx_pause_sent(tx_pause_sent), .sqe_active(sqe_active));

// ==== verification/mres_phy_model.sv ====
`timescale 1ns/1ps
// Purpose: phy side of the mii, receive frames and sqe echo
// Assumes: levels synchronous to clk
// Notes: echo lands well inside the 96 bit window
module mres_phy_model (
  input  wire logic clk,
  input  wire logic send,
  input  wire logic bad,
  input  wire logic echo,
  input  wire logic tx_en,
  output logic      rx_dv,
  output logic      rx_er,
  output logic      col
);
  logic [3:0] rx_cnt = 4'h0;
  logic [4:0] col_cnt = 5'h0;
  logic       tx_d = 1'b0;
  always_ff @(posedge clk) begin
    tx_d <= tx_en;
    if (send) rx_cnt <= 4'h4;
    else if (rx_cnt != 4'h0) rx_cnt <= rx_cnt - 4'h1;
    if (tx_d && !tx_en && echo) col_cnt <= 5'h0c;
    else if (col_cnt != 5'h0) col_cnt <= col_cnt - 5'h1;
  end
  assign rx_dv = rx_cnt != 4'h0;
  assign rx_er = bad && rx_cnt == 4'h2;
  assign col   = col_cnt != 5'h0 && col_cnt < 5'h5;
endmodule

// ==== verification/mres_top_bench.sv ====
`timescale 1ns/1ps
// Purpose: self checking bench for the receive error counters
// Assumes: zero wait apb answer, frame info valid with the end strobe
// Notes: counters are judged only by bus reads
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %0t value mismatch", $time); end end
module mres_top_bench;
  logic        clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_data;
  logic        pready, pslverr, rd_err, rx_dv, rx_er, col, sqe_active;
  logic        rx_frame_end = 1'b0, rx_crc_err = 1'b0, rx_align_err = 1'b0;
  logic [13:0] rx_frame_len = 14'h0;
  logic [15:0] rx_len_field = 16'h0;
  logic        tx_en = 1'b0, tx_pause_sent = 1'b0, send = 1'b0, bad = 1'b0, echo = 1'b0;
  int          fails = 0, tests_run = 0, cycles = 0;
  mres_top dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_dv(rx_dv), .rx_er(rx_er), .rx_frame_end(rx_frame_end),
    .rx_frame_len(rx_frame_len), .rx_len_field(rx_len_field), .rx_crc_err(rx_crc_err),
    .rx_align_err(rx_align_err), .tx_en(tx_en), .col(col), .tx_pause_sent(tx_pause_sent),
    .sqe_active(sqe_active));
  mres_phy_model phy (.clk(clk), .send(send), .bad(bad), .echo(echo), .tx_en(tx_en),
    .rx_dv(rx_dv), .rx_er(rx_er), .col(col));
  initial begin
    forever #4 clk = ~clk;
  end
  task print_verdict;
    if (fails == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      print_verdict();
    end
  end
  // request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd_data = prdata;
    rd_err  = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd_data, e)
  endtask
  task frame(input logic [13:0] len, input logic [15:0] fld, input logic [1:0] ce,
             input logic er);
    send <= 1'b1; bad <= er;
    @(posedge clk);
    send <= 1'b0;
    repeat (5) @(posedge clk);
    rx_frame_end <= 1'b1; rx_frame_len <= len; rx_len_field <= fld;
    rx_crc_err <= ce[1]; rx_align_err <= ce[0];
    @(posedge clk);
    rx_frame_end <= 1'b0; bad <= 1'b0;
    @(posedge clk);
  endtask
  task tx_burst(input logic e);
    echo <= e; tx_en <= 1'b1;
    repeat (20) @(posedge clk);
    tx_en <= 1'b0;
    repeat (200) @(posedge clk);
  endtask
  task t_regs;
    apb(1'b1, 8'h24, 32'hffff_ffff);
    for (int a = 0; a <= 'h24; a += 4) begin
      rd(a[7:0], 32'h0);
      `CHK(rd_err, a > 'h20)
    end
    apb(1'b1, mres_pkg::ADDR_SYMBOL, 32'hffff_ffff);
    rd(mres_pkg::ADDR_SYMBOL, 32'h0000_00ff);
    apb(1'b1, mres_pkg::ADDR_PAUSE, 32'hffff_ffff);
    rd(mres_pkg::ADDR_PAUSE, 32'h0000_ffff);
    apb(1'b1, mres_pkg::ADDR_SYMBOL, 32'h0);
    apb(1'b1, mres_pkg::ADDR_PAUSE, 32'h0);
    apb(1'b1, mres_pkg::ADDR_CONFIG, 32'hffff_ffff);
    rd(mres_pkg::ADDR_CONFIG, 32'h0001_010b);
    apb(1'b1, mres_pkg::ADDR_CONFIG, 32'h0);
  endtask
  task t_sizes;
    frame(14'd63, 16'h0800, 2'b00, 1'b0);
    frame(14'd64, 16'h0800, 2'b00, 1'b1);
    frame(14'd1518, 16'h0800, 2'b00, 1'b0);
    frame(14'd1519, 16'h0800, 2'b00, 1'b0);
    frame(14'd1519, 16'h0800, 2'b01, 1'b0);
    frame(14'd1600, 16'h0800, 2'b00, 1'b1);
    frame(14'd63, 16'h0800, 2'b10, 1'b0);
    rd(mres_pkg::ADDR_SYMBOL, 32'h2);
    rd(mres_pkg::ADDR_FCS, 32'h1);
    rd(mres_pkg::ADDR_JABBER, 32'h2);
    rd(mres_pkg::ADDR_EXCESS, 32'h1);
    rd(mres_pkg::ADDR_UNDER, 32'h1);
    apb(1'b1, mres_pkg::ADDR_CONFIG, 32'h0000_0100);
    frame(14'd1536, 16'h0800, 2'b00, 1'b0);
    frame(14'd1537, 16'h0800, 2'b00, 1'b0);
    rd(mres_pkg::ADDR_EXCESS, 32'h2);
    apb(1'b1, mres_pkg::ADDR_CONFIG, 32'h0000_0108);
    frame(14'd10240, 16'h0800, 2'b00, 1'b0);
    frame(14'd10241, 16'h0800, 2'b00, 1'b0);
    rd(mres_pkg::ADDR_EXCESS, 32'h3);
  endtask
  task t_mismatch;
    apb(1'b1, mres_pkg::ADDR_CONFIG, 32'h0);
    frame(14'd100, 16'h00c8, 2'b00, 1'b0);
    rd(mres_pkg::ADDR_MISMATCH, 32'h0);
    apb(1'b1, mres_pkg::ADDR_CONFIG, 32'h0001_0000);
    frame(14'd100, 16'h00c8, 2'b00, 1'b0);
    frame(14'd100, 16'h0600, 2'b00, 1'b0);
    frame(14'd100, 16'h05ff, 2'b00, 1'b0);
    frame(14'd100, 16'h0064, 2'b00, 1'b0);
    frame(14'd1519, 16'h05ff, 2'b00, 1'b0);
    rd(mres_pkg::ADDR_MISMATCH, 32'h2);
  endtask
  task t_sqe;
    apb(1'b1, mres_pkg::ADDR_CONFIG, 32'h1);
    tx_burst(1'b1);
    rd(mres_pkg::ADDR_SQE, 32'h0);
    tx_burst(1'b0);
    rd(mres_pkg::ADDR_SQE, 32'h1);
    apb(1'b1, mres_pkg::ADDR_CONFIG, 32'h0);
    tx_burst(1'b0);
    rd(mres_pkg::ADDR_SQE, 32'h1);
    apb(1'b1, mres_pkg::ADDR_CONFIG, 32'h3);
    tx_burst(1'b0);
    rd(mres_pkg::ADDR_SQE, 32'h1);
    repeat (1100) @(posedge clk);
    rd(mres_pkg::ADDR_SQE, 32'h2);
  endtask
  task t_pause;
    tx_pause_sent <= 1'b1;
    repeat (3) @(posedge clk);
    tx_pause_sent <= 1'b0;
    @(posedge clk);
    rd(mres_pkg::ADDR_PAUSE, 32'h3);
    apb(1'b1, mres_pkg::ADDR_PAUSE, 32'h0000_ffff);
    tx_pause_sent <= 1'b1;
    @(posedge clk);
    tx_pause_sent <= 1'b0;
    @(posedge clk);
    rd(mres_pkg::ADDR_PAUSE, 32'h0);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_sizes();
    t_mismatch();
    t_sqe();
    t_pause();
    print_verdict();
  end
endmodule
